// ==== logic/rd_pkg.sv ====
// types, opcodes and counts of the serial flash read path
// assumes a SystemVerilog tool; shared by the read path top and the bench
package rd_pkg;
  localparam int                 DUMMY_W    = 5;
  localparam int                 SFDP_AW    = 8;
  localparam logic [7:0]         OP_READ    = 8'h03;
  localparam logic [7:0]         OP_READ4   = 8'h13;
  localparam logic [7:0]         OP_FAST    = 8'h0B;
  localparam logic [7:0]         OP_FAST4   = 8'h0C;
  localparam logic [7:0]         OP_OOUT    = 8'h8B;
  localparam logic [7:0]         OP_OOUT4   = 8'h7C;
  localparam logic [7:0]         OP_OIO     = 8'hCB;
  localparam logic [7:0]         OP_OIO4    = 8'hCC;
  localparam logic [7:0]         OP_DOUT    = 8'h9D;
  localparam logic [7:0]         OP_DIO     = 8'hFD;
  localparam logic [7:0]         OP_SFDP    = 8'h5A;
  localparam logic [DUMMY_W-1:0] SFDP_DUMMY = 5'h08;
  localparam logic [5:0]         CMD_LAST   = 6'h07;
  localparam logic [7:0]         OE_ONE     = 8'h02;
  localparam logic [7:0]         OE_ALL     = 8'hFF;
  localparam logic [31:0]        STEP_ONE   = 32'h0000_0001;
  localparam logic [31:0]        STEP_TWO   = 32'h0000_0002;

  typedef enum logic [2:0] {L_CMD, L_ADDR, L_DUMMY, L_DATA, L_IGNORE} link_st_e;

  typedef struct packed {
    logic               ce;
    logic               a4nv;
    logic               a4mode;
    logic               octal_ddr;
    logic               ddr_en;
    logic [DUMMY_W-1:0] dummy;
  } cfg_s;

  typedef struct packed {
    logic               valid;
    logic               sfdp;
    logic               a8;
    logic               ad;
    logic               d8;
    logic               dd;
    logic               a4;
    logic [DUMMY_W-1:0] dummy;
  } cmd_s;

  typedef struct packed {
    link_st_e    st;
    logic [5:0]  cnt;
    logic [7:0]  op;
    cmd_s        cmd;
    logic [31:0] a;
    logic [15:0] sh;
    logic [2:0]  bcnt;
    logic [7:0]  out_n;
    logic [7:0]  out_p;
    logic [7:0]  oe;
    logic        act;
  } link_s;

  typedef struct packed {
    cfg_s s1;
    cfg_s s2;
  } sync_s;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] dq_p;
  } pos_s;

  typedef struct packed {
    logic b1;
    logic b2;
    logic busy;
  } sys_s;

  // last address clock index per address line count, rate and length
  function automatic logic [5:0] addr_last(input cmd_s c);
    unique case ({c.a8, c.ad})
      2'b00: addr_last = c.a4 ? 6'h1F : 6'h17;
      2'b01: addr_last = c.a4 ? 6'h0F : 6'h0B;
      2'b10: addr_last = c.a4 ? 6'h03 : 6'h02;
      2'b11: addr_last = 6'h01;
    endcase
  endfunction : addr_last
endpackage : rd_pkg

// ==== logic/serial_flash_read_path.sv ====
// read path of an octal serial flash: command, address, dummy, data
// assumes a host on SCLK/CS_N, config bits and loads from CLK logic
//
// Notes on behaviour
// - discovery read: 1S command, 3 address bytes, 8 dummies
// - discovery read address wraps at 256 bytes
// - discovery read ignores burst wrap, always continuous
// - select high ends read, drive stops at once
// - basic read takes 3-byte address by default
// - memory read wraps past array end
// - single-rate address bits taken on rising edge
// - address increments after every output byte
// - fast read is single line everywhere outside octal DDR
// - octal-output read returns data on eight lines
// - octal I/O read: eight-line address and data
// - DDR octal-output read: 1D address, 8D data
// - DDR commands always run double rate
// - other reads double rate only when enabled
// - 8D data transfers even byte counts
// - 4-byte mode by nonvolatile or mode bit
// - 4-byte variants take a 32-bit address
// - 4-byte octal I/O read: 1S-8S-8S, 32 bits
// - DDR octal I/O read always 32-bit, 8D
// - 4-byte configuration means four address bytes except in discovery read
// - octal DDR protocol: all phases 8D, 4 bytes
// - discovery read 3-byte, 4-byte in octal DDR
// - octal DDR forces 4-byte addressing
`timescale 1ns/100ps
module serial_flash_read_path #(
  parameter int MEM_AW = 16
) (
  input  wire logic                      CLK,
  input  wire logic                      ARST_N,
  input  wire logic                      CE,
  input  wire logic                      SCLK,
  input  wire logic                      CS_N,
  input  wire logic [7:0]                DATA_I,
  output logic [7:0]                     DATA_O,
  output logic [7:0]                     DATA_OE,
  input  wire logic                      CFG_ADDR4_NV,
  input  wire logic                      CFG_ADDR4_MODE,
  input  wire logic                      CFG_OCTAL_DDR,
  input  wire logic                      CFG_DDR_EN,
  input  wire logic [rd_pkg::DUMMY_W-1:0] CFG_DUMMY,
  input  wire logic                      LOAD_VALID,
  input  wire logic                      LOAD_SFDP,
  input  wire logic [MEM_AW-1:0]         LOAD_ADDR,
  input  wire logic [7:0]                LOAD_DATA,
  output logic                           BUSY
);

  rd_pkg::link_s l_reg;
  rd_pkg::link_s l_next;
  rd_pkg::sync_s cs_reg;
  rd_pkg::sync_s cs_next;
  rd_pkg::pos_s  p_reg;
  rd_pkg::pos_s  p_next;
  rd_pkg::sys_s  s_reg;
  rd_pkg::sys_s  s_next;
  rd_pkg::cfg_s  cfg;
  rd_pkg::cfg_s  live;
  logic [7:0]    mem [2**MEM_AW];
  logic [7:0]    sfdp_mem [2**rd_pkg::SFDP_AW];
  logic          lrst_n;

  // deselect clears the link side asynchronously
  assign lrst_n = ARST_N & ~CS_N;
  assign live   = {CE, CFG_ADDR4_NV, CFG_ADDR4_MODE, CFG_OCTAL_DDR, CFG_DDR_EN, CFG_DUMMY};
  assign cfg    = cs_reg.s2;

  function automatic logic [7:0] fetch(input logic sfdp, input logic [31:0] a);
    if (sfdp) begin
      // table index wraps by width, no burst wrap applies
      fetch = sfdp_mem[a[rd_pkg::SFDP_AW-1:0]];
    end else begin
      fetch = mem[a[MEM_AW-1:0]];
    end
  endfunction : fetch

  function automatic rd_pkg::cmd_s decode(input logic [7:0] op, input rd_pkg::cfg_s c);
    rd_pkg::cmd_s d;
    d       = '0;
    d.valid = 1'b1;
    d.a4    = c.a4nv | c.a4mode;
    unique case (op)
      rd_pkg::OP_READ: begin
        d.a4 = c.a4nv | c.a4mode;
      end
      rd_pkg::OP_READ4: begin
        d.a4 = 1'b1;
      end
      rd_pkg::OP_FAST: begin
        d.dummy = c.dummy;
      end
      rd_pkg::OP_FAST4: begin
        d.a4    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_OOUT: begin
        d.d8    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_OOUT4: begin
        d.a4    = 1'b1;
        d.d8    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_OIO: begin
        d.a8    = 1'b1;
        d.d8    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_OIO4: begin
        d.a4    = 1'b1;
        d.a8    = 1'b1;
        d.d8    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_DOUT: begin
        d.ad    = 1'b1;
        d.d8    = 1'b1;
        d.dd    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_DIO: begin
        d.a4    = 1'b1;
        d.a8    = 1'b1;
        d.ad    = 1'b1;
        d.d8    = 1'b1;
        d.dd    = 1'b1;
        d.dummy = c.dummy;
      end
      rd_pkg::OP_SFDP: begin
        d.sfdp  = 1'b1;
        d.a4    = 1'b0;
        d.dummy = rd_pkg::SFDP_DUMMY;
      end
      default: begin
        d.valid = 1'b0;
      end
    endcase
    if (c.ddr_en && !d.sfdp) begin
      d.dd = 1'b1;
    end
    if (c.octal_ddr) begin
      d.a4 = 1'b1;
      d.a8 = 1'b1;
      d.ad = 1'b1;
      d.d8 = 1'b1;
      d.dd = 1'b1;
    end
    return d;
  endfunction : decode

  // config and enable into the link domain
  always_comb begin
    cs_next.s1 = live;
    cs_next.s2 = cs_reg.s1;
  end

  always_ff @(negedge SCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_reg <= '0;
    end else begin
      cs_reg <= cs_next;
    end
  end

  // rising-edge sampling and second half of a double-rate output
  always_comb begin
    p_next = p_reg;
    if (cfg.ce) begin
      p_next.rise = DATA_I;
      p_next.dq_p = l_reg.out_p;
    end
  end

  always_ff @(posedge SCLK or negedge lrst_n) begin
    if (!lrst_n) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

  // command, address, dummy and data sequencer on the falling edge
  always_comb begin
    logic [7:0]  opn;
    logic [15:0] cur;
    logic        ld;
    opn    = l_reg.op;
    cur    = l_reg.sh;
    ld     = 1'b0;
    l_next = l_reg;
    if (cfg.ce) begin
      unique case (l_reg.st)
        rd_pkg::L_CMD: begin
          // serial_line_zero carries the opcode unless octal DDR
          opn         = cfg.octal_ddr ? p_reg.rise : {l_reg.op[6:0], p_reg.rise[0]};
          l_next.op   = opn;
          l_next.cnt  = l_reg.cnt + 6'h01;
          if (cfg.octal_ddr || l_reg.cnt == rd_pkg::CMD_LAST) begin
            l_next.cmd = decode(opn, cfg);
            l_next.cnt = rd_pkg::addr_last(l_next.cmd);
            l_next.st  = l_next.cmd.valid ? rd_pkg::L_ADDR : rd_pkg::L_IGNORE;
          end
        end
        rd_pkg::L_ADDR: begin
          unique case ({l_reg.cmd.a8, l_reg.cmd.ad})
            2'b00: l_next.a = {l_reg.a[30:0], p_reg.rise[0]};
            2'b01: l_next.a = {l_reg.a[29:0], p_reg.rise[0], DATA_I[0]};
            2'b10: l_next.a = {l_reg.a[23:0], p_reg.rise};
            2'b11: l_next.a = {l_reg.a[15:0], p_reg.rise, DATA_I};
          endcase
          l_next.cnt = l_reg.cnt - 6'h01;
          if (l_reg.cnt == 6'h00) begin
            if (l_reg.cmd.dd) begin
              l_next.a[0] = 1'b0;
            end
            l_next.cnt = {1'b0, l_reg.cmd.dummy} - 6'h01;
            l_next.st  = (l_reg.cmd.dummy == '0) ? rd_pkg::L_DATA : rd_pkg::L_DUMMY;
          end
        end
        rd_pkg::L_DUMMY: begin
          l_next.cnt = l_reg.cnt - 6'h01;
          if (l_reg.cnt == 6'h00) begin
            l_next.st = rd_pkg::L_DATA;
          end
        end
        rd_pkg::L_DATA, rd_pkg::L_IGNORE: begin
          l_next.st = l_reg.st;
        end
      endcase
      if (l_next.st == rd_pkg::L_DATA) begin
        l_next.act = 1'b1;
        l_next.oe  = l_reg.cmd.d8 ? rd_pkg::OE_ALL : rd_pkg::OE_ONE;
        if (l_reg.cmd.d8) begin
          l_next.out_n = fetch(l_reg.cmd.sfdp, l_next.a);
          l_next.out_p = fetch(l_reg.cmd.sfdp, l_next.a + rd_pkg::STEP_ONE);
          // pairs of bytes per clock keep double rate counts even
          l_next.a     = l_next.a + (l_reg.cmd.dd ? rd_pkg::STEP_TWO : rd_pkg::STEP_ONE);
        end else begin
          ld           = (l_reg.bcnt == 3'h0);
          cur          = ld ? {fetch(l_reg.cmd.sfdp, l_next.a), 8'h00} : l_reg.sh;
          l_next.out_n = {6'h00, cur[15], 1'b0};
          l_next.out_p = {6'h00, cur[14], 1'b0};
          l_next.sh    = l_reg.cmd.dd ? cur << 2 : cur << 1;
          l_next.bcnt  = l_reg.bcnt + (l_reg.cmd.dd ? 3'h2 : 3'h1);
          if (ld) begin
            l_next.a = l_next.a + rd_pkg::STEP_ONE;
          end
        end
      end
    end
  end

  always_ff @(negedge SCLK or negedge lrst_n) begin
    if (!lrst_n) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // data phase activity into the system clock domain
  always_comb begin
    s_next = s_reg;
    if (CE) begin
      s_next.b1   = l_reg.act;
      s_next.b2   = s_reg.b1;
      s_next.busy = s_reg.b2;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // array and table loads from the system side
  always_ff @(posedge CLK) begin
    if (CE && LOAD_VALID) begin
      if (LOAD_SFDP) begin
        sfdp_mem[LOAD_ADDR[rd_pkg::SFDP_AW-1:0]] <= LOAD_DATA;
      end else begin
        mem[LOAD_ADDR] <= LOAD_DATA;
      end
    end
  end

  // double rate: falling-edge byte while low, rising-edge byte while high
  assign DATA_O  = (l_reg.cmd.dd && SCLK) ? p_reg.dq_p : l_reg.out_n;
  assign DATA_OE = l_reg.oe;
  assign BUSY    = s_reg.busy;

  sequence sfdp_dummy_s;
    (l_reg.st == rd_pkg::L_DUMMY) [*8];
  endsequence

  sequence oddr_addr_s;
    (l_reg.st == rd_pkg::L_ADDR) [*2];
  endsequence

  sequence oio3_addr_s;
    (l_reg.st == rd_pkg::L_ADDR) [*3];
  endsequence

  chk_sel_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
    CS_N |-> DATA_OE == 8'h00) else $error("data driven while deselected");

  chk_unknown_quiet: assert property (@(negedge SCLK) disable iff (!lrst_n)
    l_reg.st == rd_pkg::L_IGNORE |=> l_reg.st == rd_pkg::L_IGNORE && l_reg.oe == 8'h00)
    else $error("unknown opcode left the ignore state");

  chk_sfdp_wrap: assert property (@(negedge SCLK) disable iff (!lrst_n)
    l_reg.cmd.sfdp && $past(l_reg.a[7:0]) == 8'hFF && $changed(l_reg.a)
    |-> l_reg.a[7:0] == 8'h00) else $error("table address did not wrap");

  chk_addr_step: assert property (@(negedge SCLK) disable iff (!lrst_n)
    l_reg.st == rd_pkg::L_DATA && $past(l_reg.st) == rd_pkg::L_DATA && l_reg.cmd.d8
    && !l_reg.cmd.dd && $past(cfg.ce) |-> l_reg.a == $past(l_reg.a) + 32'h0000_0001)
    else $error("address did not step by one byte");

  chk_ddr_even: assert property (@(negedge SCLK) disable iff (!lrst_n)
    l_reg.st == rd_pkg::L_DATA && l_reg.cmd.dd && l_reg.cmd.d8 |-> !l_reg.a[0])
    else $error("odd byte address in double rate");

  chk_sfdp_dummy: assert property (@(negedge SCLK) disable iff (!lrst_n)
    $rose(l_reg.st == rd_pkg::L_DUMMY) && l_reg.cmd.sfdp && cfg.ce
    |-> sfdp_dummy_s ##1 l_reg.st == rd_pkg::L_DATA) else $error("table read dummy count wrong");

  chk_oddr_addr: assert property (@(negedge SCLK) disable iff (!lrst_n)
    $rose(l_reg.st == rd_pkg::L_ADDR) && cfg.octal_ddr && cfg.ce
    |-> oddr_addr_s ##1 l_reg.st != rd_pkg::L_ADDR) else $error("octal ddr address not 4 bytes");

  chk_oio_3byte: assert property (@(negedge SCLK) disable iff (!lrst_n)
    $rose(l_reg.st == rd_pkg::L_ADDR) && l_reg.cmd.a8 && !l_reg.cmd.ad && !l_reg.cmd.a4 && cfg.ce
    |-> oio3_addr_s ##1 l_reg.st != rd_pkg::L_ADDR) else $error("octal 3-byte address length wrong");

  chk_ddr_cmd: assert property (@(negedge SCLK) disable iff (!lrst_n)
    l_reg.st != rd_pkg::L_CMD && l_reg.op == rd_pkg::OP_DOUT |-> l_reg.cmd.dd && l_reg.cmd.d8)
    else $error("ddr opcode not run at double rate");

endmodule : serial_flash_read_path

// ==== test/tb_top.sv ====
// bench of the read path: loads array and table, runs read frames
// assumes the design package and the host model compile first
`timescale 1ns/100ps
module tb_top;
  localparam int AW = 9;
  logic                       clk;
  logic                       arst_n;
  logic                       ce;
  logic [7:0]                 host_d;
  logic [7:0]                 data_i;
  logic [7:0]                 data_o;
  logic [7:0]                 data_oe;
  logic                       sclk;
  logic                       cs_n;
  logic                       a4nv;
  logic                       a4mode;
  logic                       od;
  logic                       ddr_en;
  logic [rd_pkg::DUMMY_W-1:0] cfg_dummy;
  logic                       load_valid;
  logic                       load_sfdp;
  logic [AW-1:0]              load_addr;
  logic [7:0]                 load_data;
  logic                       busy;
  logic [7:0]                 seed;
  logic [7:0]                 mem [512];
  logic [7:0]                 tbl [256];
  logic [15:0]                expq [$];
  int                         n_fail;
  int                         compares;

  assign data_i = (data_oe & data_o) | (~data_oe & host_d);

  always #4 clk = ~clk;

  serial_flash_read_path #(.MEM_AW(AW)) u_serial_flash_read_path (
    .CLK(clk), .ARST_N(arst_n), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .DATA_I(data_i),
    .DATA_O(data_o), .DATA_OE(data_oe), .CFG_ADDR4_NV(a4nv), .CFG_ADDR4_MODE(a4mode),
    .CFG_OCTAL_DDR(od), .CFG_DDR_EN(ddr_en), .CFG_DUMMY(cfg_dummy), .LOAD_VALID(load_valid),
    .LOAD_SFDP(load_sfdp), .LOAD_ADDR(load_addr), .LOAD_DATA(load_data), .BUSY(busy)
  );

  xspi_host u_xspi_host (
    .sclk(sclk), .cs_n(cs_n), .host_d(host_d), .data_o(data_o), .data_oe(data_oe)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  task automatic chk_rd(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk_rd

  task automatic chk_oe(input logic [7:0] e);
    chk_rd({8'h00, e}, {8'h00, data_oe});
  endtask : chk_oe

  task automatic chk_busy(input logic e);
    chk_rd({15'h0000, e}, {15'h0000, busy});
  endtask : chk_busy

  always @(u_xspi_host.rx_ev) chk_rd(expq.pop_front(), {u_xspi_host.rx_oe, u_xspi_host.rx});

  task automatic rd_frame(input logic [7:0] op, input logic [31:0] a, input int nb, input int am,
                          input int nd, input int dm, input int n, input bit t);
    for (int i = 0; i < n; i++)
      expq.push_back({dm == 0 ? rd_pkg::OE_ONE : rd_pkg::OE_ALL, t ? tbl[8'(a + i)] : mem[AW'(a + i)]});
    u_xspi_host.start();
    u_xspi_host.cmd(op, od);
    u_xspi_host.addr(a, nb, am);
    u_xspi_host.clocks(nd);
    repeat (dm == 2 ? n / 2 : n) u_xspi_host.rd(dm);
    chk_busy(1'b1);
    u_xspi_host.stop();
    #1 chk_oe(8'h00);
    #40 chk_busy(1'b0);
  endtask : rd_frame

  task automatic set_cfg(input logic nv, input logic md, input logic o);
    a4nv = nv;
    a4mode = md;
    od = o;
    u_xspi_host.clocks(2);
  endtask : set_cfg

  task automatic end_sim();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    #400_000;
    n_fail++;
    end_sim();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    ddr_en = 1'b0;
    {a4nv, a4mode, od} = 3'h0;
    cfg_dummy = 5'h02;
    {load_valid, load_sfdp, load_addr, load_data} = '0;
    seed = 8'h5C;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    u_xspi_host.clocks(2);
    for (int i = 0; i < 768; i++) begin
      @(posedge clk);
      #1 load_valid = 1'b1;
      load_sfdp = i >= 512;
      load_addr = AW'(i);
      load_data = seed;
      if (i < 512) mem[i] = seed;
      else tbl[i - 512] = seed;
      seed = lfsr(seed);
    end
    @(posedge clk);
    // enable low: this array load must not land
    #1 ce = 1'b0;
    load_sfdp = 1'b0;
    load_data = ~mem[255];
    repeat (2) @(posedge clk);
    #1 ce = 1'b1;
    load_valid = 1'b0;
    rd_frame(rd_pkg::OP_READ, 32'h0000_01FE, 3, 0, 0, 0, 3, 0);
    rd_frame(rd_pkg::OP_FAST, {8'h00, seed, seed}, 3, 0, 2, 0, 2, 0);
    rd_frame(rd_pkg::OP_SFDP, 32'h0000_00FF, 3, 0, 8, 0, 2, 1);
    rd_frame(rd_pkg::OP_OOUT, 32'h0000_0010, 3, 0, 2, 1, 2, 0);
    rd_frame(rd_pkg::OP_OIO, 32'h0000_0021, 3, 2, 2, 1, 2, 0);
    rd_frame(rd_pkg::OP_DOUT, 32'h0000_01FE, 3, 1, 2, 2, 4, 0);
    rd_frame(rd_pkg::OP_READ4, 32'h0000_0105, 4, 0, 0, 0, 1, 0);
    rd_frame(rd_pkg::OP_FAST4, 32'h0000_0133, 4, 0, 2, 0, 1, 0);
    rd_frame(rd_pkg::OP_OOUT4, 32'h0000_0144, 4, 0, 2, 1, 2, 0);
    rd_frame(rd_pkg::OP_OIO4, 32'h0000_0155, 4, 2, 2, 1, 2, 0);
    rd_frame(rd_pkg::OP_DIO, 32'h0000_0040, 4, 3, 2, 2, 2, 0);
    u_xspi_host.start();
    u_xspi_host.cmd(8'hA5, 1'b0);
    repeat (40) begin
      u_xspi_host.clocks(1);
      #1 chk_oe(8'h00);
    end
    chk_busy(1'b0);
    u_xspi_host.stop();
    for (int k = 0; k < 2; k++) begin
      set_cfg(k == 0, k == 1, 1'b0);
      rd_frame(rd_pkg::OP_READ, 32'h0000_0177, 4, 0, 0, 0, 1, 0);
      rd_frame(rd_pkg::OP_SFDP, 32'h0000_0080, 3, 0, 8, 0, 1, 1);
    end
    set_cfg(1'b0, 1'b0, 1'b1);
    rd_frame(rd_pkg::OP_FAST, 32'h0000_0130, 4, 3, 2, 2, 4, 0);
    // double rate data on an ordinary read once enabled
    ddr_en = 1'b1;
    set_cfg(1'b0, 1'b0, 1'b0);
    rd_frame(rd_pkg::OP_OOUT, 32'h0000_00FE, 3, 0, 2, 2, 2, 0);
    chk_rd(16'h0000, 16'(expq.size()));
    end_sim();
  end
endmodule : tb_top

// ==== test/xspi_host.sv ====
// host model: drives select, link clock and data lines
// assumes the bench resolves the data lines from the design's output enable
`timescale 1ns/100ps
module xspi_host (
  output logic             sclk,
  output logic             cs_n,
  output logic [7:0]       host_d,
  input  wire logic [7:0]  data_o,
  input  wire logic [7:0]  data_oe
);
  logic [7:0] rx;
  logic [7:0] rx_oe;
  event       rx_ev;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_d = 8'h3C;
  end

  // one link clock: byte for the rise, then byte for the fall
  task automatic clk2(input logic [7:0] dr, input logic [7:0] df);
    #1 host_d = dr;
    #79 sclk = 1'b1;
    #1 host_d = df;
    #79 sclk = 1'b0;
  endtask : clk2

  // idle or dummy clocks, lines keep moving
  task automatic clocks(input int n);
    repeat (n) clk2(~host_d, host_d);
  endtask : clocks

  task automatic start();
    #40 cs_n = 1'b0;
  endtask : start

  task automatic stop();
    #40 cs_n = 1'b1;
  endtask : stop

  task automatic cmd(input logic [7:0] op, input logic od);
    if (od) clk2(op, ~op);
    else for (int i = 7; i >= 0; i--) clk2({~host_d[7:1], op[i]}, ~host_d);
  endtask : cmd

  // m: 0 one line, 1 one line double rate, 2 eight lines, 3 eight lines double rate
  task automatic addr(input logic [31:0] a, input int nb, input int m);
    logic [31:0] s;
    s = a << (32 - 8 * nb);
    repeat (m == 3 ? nb / 2 : m == 2 ? nb : m == 1 ? 4 * nb : 8 * nb) begin
      case (m)
        0: clk2({~host_d[7:1], s[31]}, ~host_d);
        1: clk2({~host_d[7:1], s[31]}, {host_d[7:1], s[30]});
        2: clk2(s[31:24], ~s[31:24]);
        default: clk2(s[31:24], s[23:16]);
      endcase
      s = s << (m == 3 ? 16 : m == 2 ? 8 : m + 1);
    end
  endtask : addr

  // dm: 0 one line, 1 eight lines, 2 eight lines double rate
  task automatic rd(input int dm);
    logic [7:0] b;
    for (int i = 0; i < (dm == 0 ? 8 : 1); i++) begin
      #1 host_d = ~host_d;
      #78 b = (dm == 0) ? {b[6:0], data_o[1]} : data_o;
      rx_oe = data_oe;
      #1 sclk = 1'b1;
      if (dm == 2) begin
        rx = b;
        -> rx_ev;
        #79 b = data_o;
        #1 sclk = 1'b0;
      end else begin
        #80 sclk = 1'b0;
      end
    end
    rx = b;
    -> rx_ev;
  endtask : rd
endmodule : xspi_host
